/* File: src/cies_core.sv */
// execution unit for a subset of an 8-bit core instruction set, apb slave
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
// Summary of operation
// - the interrupt return pops the stack top into pc and sets the global enable, flags kept.
// - rotate left moves the file value up one bit through carry, only carry changes.
// - destination bit 0 sends the result to w, 1 writes it back to the file register.
// - rotate right moves the file value down one bit through carry, carry is updated.
// - the literal return loads the literal into w and pops the stack into pc, flags kept.
// - the literal return and the subroutine return each take two instruction cycles.
// - the subroutine return pops the stack and loads the popped entry into pc, flags kept.
// - power-down clears watchdog and prescaler, sets the time-out bit, clears power-down bit.
// - after those updates the core enters sleep with its oscillator halted.
// - literal subtract computes literal minus w into w and updates carry, digit carry, zero.
// - literal xor puts w xor literal into w and updates only zero.
// - file subtract computes file minus w into the destination and updates c, dc, z.
// - file xor puts w xor file into the destination and updates only zero.
// - nibble swap exchanges the file nibbles into the destination, flags kept.
module cies_core
  import cies_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int FILE_WORDS  = 128
)(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // core state
  output logic             osc_halted,
  output logic             global_irq_enable
);

  localparam int SPW = $clog2(STACK_DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]     wreg;
  logic [12:0]    pc;
  logic           carry_flag;
  logic           digit_carry_flag;
  logic           zero_flag;
  logic           timeout_status_bit;
  logic           powerdown_status_bit;
  logic [7:0]     watchdog_counter;
  logic [7:0]     wdt_prescaler;
  logic [6:0]     file_addr;
  logic [13:0]    last_instr;
  logic [1:0]     cyc_count;
  logic [SPW-1:0] sp;
  logic [12:0]    stack_mem [STACK_DEPTH];
  logic [7:0]     file_mem  [FILE_WORDS];

  logic [7:0]     next_wreg;
  logic [12:0]    next_pc;
  logic           next_carry;
  logic           next_dc;
  logic           next_zero;
  logic           next_to;
  logic           next_pd;
  logic           next_gie;
  logic           next_halt;
  logic [7:0]     next_wdt;
  logic [7:0]     next_pre;
  logic [6:0]     next_faddr;
  logic [13:0]    next_instr;
  logic [1:0]     next_cyc;
  logic [SPW-1:0] next_sp;
  logic           next_pready;
  logic [31:0]    next_prdata;
  logic           next_slverr;
  logic           stk_we;
  logic [12:0]    stk_wdata;
  logic           file_we;
  logic [6:0]     file_waddr;
  logic [7:0]     file_wdata;

  ////////////////////////////////////////////////////////////////////////////////
  // decode of the word on the bus
  logic [13:0] op;
  logic [7:0]  lit;
  logic [6:0]  faddr_op;
  logic [7:0]  fval;
  logic        dest_file;
  logic        is_two_cycle;
  logic [8:0]  sub_sum;
  logic [4:0]  sub_nib;
  logic [7:0]  sub_a;
  logic [7:0]  status_rd;
  logic        access;

  // standard word layout
  // field extraction
  assign op        = pwdata[13:0];
  assign lit       = op[7:0];
  assign faddr_op  = op[6:0];
  assign dest_file = op[OP_DEST_BIT];
  assign fval      = file_mem[faddr_op];
  assign access    = psel & penable & ~pready;

  assign is_two_cycle = (op == OP_RETURN) || (op == OP_RETURN_FROM_IRQ_OP) || (op[13:10] == OP_RETURN_LITERAL_OP);

  // subtract by adding the complement plus one; carry out means no borrow
  assign sub_a   = (op[13:9] == OP_SUB_FROM_LITERAL_OP) ? lit : fval;
  assign sub_sum = {1'b0, sub_a} + {1'b0, ~wreg} + 9'h001;
  assign sub_nib = {1'b0, sub_a[3:0]} + {1'b0, ~wreg[3:0]} + 5'h01;

  assign status_rd = {1'b0, osc_halted, global_irq_enable, timeout_status_bit,
                      powerdown_status_bit, zero_flag, digit_carry_flag, carry_flag};

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic [7:0] res;
    logic       wr_res;
    logic       exec;
    res         = 8'h00;
    wr_res      = 1'b0;
    exec        = 1'b0;
    next_wreg   = wreg;
    next_pc     = pc;
    next_carry  = carry_flag;
    next_dc     = digit_carry_flag;
    next_zero   = zero_flag;
    next_to     = timeout_status_bit;
    next_pd     = powerdown_status_bit;
    next_gie    = global_irq_enable;
    next_halt   = osc_halted;
    next_faddr  = file_addr;
    next_instr  = last_instr;
    next_cyc    = cyc_count;
    next_sp     = sp;
    next_pready = 1'b0;
    next_prdata = 32'h0000_0000;
    next_slverr = 1'b0;
    stk_we      = 1'b0;
    stk_wdata   = pwdata[12:0];
    file_we     = 1'b0;
    file_waddr  = file_addr;
    file_wdata  = pwdata[7:0];
    // watchdog runs on its own, even while halted
    {next_wdt, next_pre} = {watchdog_counter, wdt_prescaler} + 16'h0001;

    if (access)
    begin
      next_pready = 1'b1;
      if (pwrite && paddr == ADDR_INSTR)
      begin
        if (osc_halted)
          // no execution while asleep
          next_slverr = 1'b1;
        else if (is_two_cycle && cyc_count != CYC_BRANCH)
        begin
          // hold the bus one more cycle for the second instruction cycle
          next_pready = 1'b0;
          next_cyc    = CYC_BRANCH;
        end
        else
          exec = 1'b1;
      end
      else if (pwrite)
      begin
        case (paddr)
          ADDR_WREG:      next_wreg = pwdata[7:0];
          ADDR_STATUS:
          begin
            // power bits are read-only; sleep bit can only be cleared (wake)
            next_carry = pwdata[STAT_C];
            next_dc    = pwdata[STAT_DC];
            next_zero  = pwdata[STAT_Z];
            next_gie   = pwdata[STAT_GIE];
            if (!pwdata[STAT_SLEEP])
              next_halt = 1'b0;
          end
          ADDR_PC:        next_pc = pwdata[12:0];
          ADDR_FILE_ADDR: next_faddr = pwdata[6:0];
          ADDR_FILE_DATA: file_we = 1'b1;
          ADDR_STACK:
          begin
            // push, as a call would; wraps like the hardware stack
            stk_we  = 1'b1;
            next_sp = sp + 1'b1;
          end
          ADDR_WATCHDOG:  next_slverr = 1'b1;
          default:        next_slverr = 1'b1;
        endcase
      end
      else
      begin
        case (paddr)
          ADDR_INSTR:     next_prdata = {18'h00000, last_instr};
          ADDR_WREG:      next_prdata = {24'h000000, wreg};
          ADDR_STATUS:    next_prdata = {24'h000000, status_rd};
          ADDR_PC:        next_prdata = {19'h00000, pc};
          ADDR_FILE_ADDR: next_prdata = {25'h0000000, file_addr};
          ADDR_FILE_DATA: next_prdata = {24'h000000, file_mem[file_addr]};
          ADDR_STACK:     next_prdata = {19'h00000, stack_mem[sp - 1'b1]};
          ADDR_WATCHDOG:  next_prdata = {24'h000000, watchdog_counter};
          default:        next_slverr = 1'b1;
        endcase
      end
    end

    if (exec)
    begin
      next_instr = op;
      next_cyc   = CYC_SINGLE;
      next_pc    = pc + 13'h0001;
      if (op == OP_RETURN || op == OP_RETURN_FROM_IRQ_OP || op[13:10] == OP_RETURN_LITERAL_OP)
      begin
        next_sp = sp - 1'b1;
        next_pc = stack_mem[sp - 1'b1];
        if (op == OP_RETURN_FROM_IRQ_OP)
          next_gie = 1'b1;
        if (op[13:10] == OP_RETURN_LITERAL_OP)
          next_wreg = lit;
      end
      else if (op == OP_SLEEP)
      begin
        next_wdt = 8'h00;
        next_pre = 8'h00;
        next_to  = 1'b1;
        next_pd  = 1'b0;
        next_halt = 1'b1;
      end
      else if (op[13:9] == OP_SUB_FROM_LITERAL_OP)
      begin
        next_wreg  = sub_sum[7:0];
        next_carry = sub_sum[8];
        next_dc    = sub_nib[4];
        next_zero  = (sub_sum[7:0] == 8'h00);
      end
      else if (op[13:8] == OP_XOR_LITERAL_OP)
      begin
        next_wreg = wreg ^ lit;
        next_zero = ((wreg ^ lit) == 8'h00);
      end
      else
      begin
        wr_res = 1'b1;
        case (op[13:8])
          OP_RLF:
          begin
            res        = {fval[6:0], carry_flag};
            next_carry = fval[7];
          end
          OP_RRF:
          begin
            res        = {carry_flag, fval[7:1]};
            next_carry = fval[0];
          end
          OP_SUB_FROM_FILE_OP:
          begin
            res        = sub_sum[7:0];
            next_carry = sub_sum[8];
            next_dc    = sub_nib[4];
            next_zero  = (sub_sum[7:0] == 8'h00);
          end
          OP_XOR_FILE_OP:
          begin
            res       = wreg ^ fval;
            next_zero = ((wreg ^ fval) == 8'h00);
          end
          OP_NIBBLE_SWAP_OP:
            res = {fval[3:0], fval[7:4]};
          default:
            // no-op and unlisted words only advance pc
            wr_res = 1'b0;
        endcase
      end
      if (wr_res)
      begin
        if (dest_file)
        begin
          file_we    = 1'b1;
          file_waddr = faddr_op;
          file_wdata = res;
        end
        else
          next_wreg = res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wreg                 <= RST_WREG;
      pc                   <= RST_PC;
      carry_flag           <= 1'b0;
      digit_carry_flag     <= 1'b0;
      zero_flag            <= 1'b0;
      timeout_status_bit   <= RST_TO;
      powerdown_status_bit <= RST_PD;
      global_irq_enable    <= 1'b0;
      osc_halted           <= 1'b0;
      watchdog_counter     <= 8'h00;
      wdt_prescaler        <= 8'h00;
      file_addr            <= 7'h00;
      last_instr           <= OP_NOP;
      cyc_count            <= CYC_SINGLE;
      sp                   <= '0;
      pready               <= 1'b0;
      prdata               <= 32'h0000_0000;
      pslverr              <= 1'b0;
    end
    else
    begin
      wreg                 <= next_wreg;
      pc                   <= next_pc;
      carry_flag           <= next_carry;
      digit_carry_flag     <= next_dc;
      zero_flag            <= next_zero;
      timeout_status_bit   <= next_to;
      powerdown_status_bit <= next_pd;
      global_irq_enable    <= next_gie;
      osc_halted           <= next_halt;
      watchdog_counter     <= next_wdt;
      wdt_prescaler        <= next_pre;
      file_addr            <= next_faddr;
      last_instr           <= next_instr;
      cyc_count            <= next_cyc;
      sp                   <= next_sp;
      pready               <= next_pready;
      prdata               <= next_prdata;
      pslverr              <= next_slverr;
    end
  end

  // memories carry no reset; contents are software's to set up
  always_ff @(posedge pclk)
  begin
    if (stk_we)
      stack_mem[sp] <= stk_wdata;
    if (file_we)
      file_mem[file_waddr] <= file_wdata;
  end

endmodule

/* File: src/cies_pkg.sv */
// package: constants for the instruction execution subset
package cies_pkg;
  // apb register byte offsets
  localparam logic [7:0] ADDR_INSTR     = 8'h00;
  localparam logic [7:0] ADDR_WREG      = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_PC        = 8'h0c;
  localparam logic [7:0] ADDR_FILE_ADDR = 8'h10;
  localparam logic [7:0] ADDR_FILE_DATA = 8'h14;
  localparam logic [7:0] ADDR_STACK     = 8'h18;
  localparam logic [7:0] ADDR_WATCHDOG  = 8'h1c;
  // status register bit positions
  localparam int STAT_C     = 0;
  localparam int STAT_DC    = 1;
  localparam int STAT_Z     = 2;
  localparam int STAT_PD    = 3;
  localparam int STAT_TO    = 4;
  localparam int STAT_GIE   = 5;
  localparam int STAT_SLEEP = 6;
  // reset values
  localparam logic       RST_TO    = 1'b1;
  localparam logic       RST_PD    = 1'b1;
  localparam logic [7:0] RST_WREG  = 8'h00;
  localparam logic [12:0] RST_PC   = 13'h0000;
  // instruction word fields
  localparam int OP_DEST_BIT = 7;
  // full-word opcodes
  localparam logic [13:0] OP_NOP    = 14'h0000;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETURN_FROM_IRQ_OP = 14'h0009;
  localparam logic [13:0] OP_SLEEP  = 14'h0063;
  // opcode prefixes on bits 13:8
  localparam logic [5:0] OP_SUB_FROM_FILE_OP = 6'h02;
  localparam logic [5:0] OP_XOR_FILE_OP = 6'h06;
  localparam logic [5:0] OP_RRF   = 6'h0c;
  localparam logic [5:0] OP_RLF   = 6'h0d;
  localparam logic [5:0] OP_NIBBLE_SWAP_OP = 6'h0e;
  localparam logic [5:0] OP_XOR_LITERAL_OP = 6'h3a;
  // prefix on bits 13:10 and on bits 13:9
  localparam logic [3:0] OP_RETURN_LITERAL_OP = 4'hd;
  localparam logic [4:0] OP_SUB_FROM_LITERAL_OP = 5'h1e;
  // timing: instruction cycles per op
  localparam logic [1:0] CYC_BRANCH = 2'h2;
  localparam logic [1:0] CYC_SINGLE = 2'h1;
endpackage

/* File: testbench/cies_core_chk.sv */
// checker: bus and execution properties of the core
`timescale 1ns/1ps
module cies_core_chk
  import cies_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // core state
  input wire logic        osc_halted,
  input wire logic        global_irq_enable
);
  logic iw;
  assign iw = psel && pwrite && paddr == ADDR_INSTR;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_unmapped_err: assert property (psel && $rose(penable) && paddr > ADDR_WATCHDOG
    |=> pready && pslverr) else $error("unmapped access not refused");
  a_wdt_readonly: assert property (psel && $rose(penable) && pwrite && paddr == ADDR_WATCHDOG
    |=> pready && pslverr) else $error("watchdog write not refused");
  a_return_two: assert property (
    iw && $rose(penable) && !osc_halted && pwdata[13:0] == OP_RETURN |=> !pready ##1 pready)
    else $error("return not two cycles");
  a_return_from_irq_op_gie: assert property (
    iw && $rose(penable) && !osc_halted && pwdata[13:0] == OP_RETURN_FROM_IRQ_OP
    |-> ##[1:3] global_irq_enable) else $error("interrupt return left enable low");
  a_sleep_halts: assert property (
    iw && $rose(penable) && !osc_halted && pwdata[13:0] == OP_SLEEP |-> ##[1:3] osc_halted)
    else $error("power-down did not halt");
  a_halt_refuse: assert property (iw && $rose(penable) && osc_halted
    |-> ##[1:3] (pready && pslverr)) else $error("instruction accepted while halted");
  // only a status write may wake the core
  a_halt_holds: assert property (osc_halted && !(psel && pwrite && paddr == ADDR_STATUS)
    |=> osc_halted) else $error("core woke by itself");
  c_err: cover property (pslverr);
  c_sleep: cover property ($rose(osc_halted));
  c_gie: cover property ($rose(global_irq_enable));
endmodule

bind cies_core cies_core_chk i_cies_core_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .osc_halted(osc_halted),
  .global_irq_enable(global_irq_enable));

/* File: testbench/tb_top.sv */
// testbench: apb-driven checks of the execution subset
`timescale 1ns/1ps
module tb_top
  import cies_pkg::*;
;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        osc_halted;
  logic        global_irq_enable;
  logic [31:0] rd;
  logic        er;
  int          waits;
  int          failures    = 0;
  int          check_count = 0;

  always #2 pclk = ~pclk;

  cies_core i_cies_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .osc_halted(osc_halted), .global_irq_enable(global_irq_enable));
  ////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    do
    begin
      @(posedge pclk);
      waits++;
    end
    while (pready !== 1'b1 && waits < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (waits >= 50)
    begin
      failures++;
      $display("[FAIL] %0t apb wait timed out", $time);
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic flags(input logic [2:0] e);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, e});
  endtask
  task automatic ex(input logic [13:0] op);
    wr(ADDR_INSTR, {18'h0, op});
  endtask
  // file operand always lives at address 0x20
  task automatic setf(input logic [7:0] v);
    wr(ADDR_FILE_ADDR, 32'h20);
    wr(ADDR_FILE_DATA, {24'h0, v});
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_sub();
    rdc(ADDR_STATUS, 32'h18);
    wr(ADDR_WREG, 32'h5);
    ex(14'h3c03);
    rdc(ADDR_WREG, 32'hfe);
    flags(3'b000);
    wr(ADDR_WREG, 32'h3);
    ex(14'h3d03);
    flags(3'b111);
    setf(8'h10);
    wr(ADDR_WREG, 32'h1);
    ex(14'h0220);
    rdc(ADDR_WREG, 32'h0f);
    flags(3'b001);
    rdc(ADDR_FILE_DATA, 32'h10);
    ex(14'h02a0);
    // w now holds 0x0f from the previous subtract: 0x10 - 0x0f
    rdc(ADDR_FILE_DATA, 32'h01);
    $display("test subtract done");
  endtask

  task automatic t_xor();
    wr(ADDR_STATUS, 32'h1);
    wr(ADDR_WREG, 32'hf0);
    ex(14'h3aff);
    rdc(ADDR_WREG, 32'h0f);
    flags(3'b001);
    setf(8'h0f);
    ex(14'h06a0);
    rdc(ADDR_FILE_DATA, 32'h0);
    flags(3'b101);
    $display("test xor done");
  endtask

  task automatic t_rot_swap();
    wr(ADDR_STATUS, 32'h5);
    setf(8'h81);
    ex(14'h0da0);
    rdc(ADDR_FILE_DATA, 32'h03);
    flags(3'b101);
    wr(ADDR_STATUS, 32'h0);
    ex(14'h0c20);
    rdc(ADDR_WREG, 32'h01);
    flags(3'b001);
    wr(ADDR_STATUS, 32'h2);
    setf(8'ha5);
    ex(14'h0e20);
    rdc(ADDR_WREG, 32'h5a);
    flags(3'b010);
    wr(ADDR_PC, 32'h40);
    ex(14'h0000);
    chk(32'(waits), 32'h2);
    rdc(ADDR_PC, 32'h41);
    rdc(ADDR_WREG, 32'h5a);
    flags(3'b010);
    $display("test rotate swap nop done");
  endtask

  task automatic t_returns();
    wr(ADDR_STACK, 32'h123);
    ex(OP_RETURN);
    chk(32'(waits), 32'h3);
    rdc(ADDR_PC, 32'h123);
    wr(ADDR_STACK, 32'h456);
    wr(ADDR_STATUS, 32'h7);
    ex(14'h3477);
    chk(32'(waits), 32'h3);
    rdc(ADDR_WREG, 32'h77);
    rdc(ADDR_PC, 32'h456);
    flags(3'b111);
    wr(ADDR_STACK, 32'habc);
    ex(OP_RETURN_FROM_IRQ_OP);
    rdc(ADDR_PC, 32'habc);
    chk({31'h0, global_irq_enable}, 32'h1);
    flags(3'b111);
    $display("test returns done");
  endtask

  task automatic t_sleep_err();
    // let the watchdog count past a prescaler wrap so the clear is visible
    repeat (300) @(posedge pclk);
    apb(1'b0, ADDR_WATCHDOG, 32'h0);
    chk({31'h0, rd[7:0] != 8'h00}, 32'h1);
    ex(OP_SLEEP);
    chk({31'h0, osc_halted}, 32'h1);
    rdc(ADDR_WATCHDOG, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk({28'h0, rd[6:3]}, 32'he);
    ex(14'h0000);
    chk({31'h0, er}, 32'h1);
    rdc(ADDR_PC, 32'habd);
    wr(ADDR_STATUS, 32'h0);
    chk({31'h0, osc_halted}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, er}, 32'h1);
    wr(ADDR_WATCHDOG, 32'h5);
    chk({31'h0, er}, 32'h1);
    $display("test sleep and errors done");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_sub();
    t_xor();
    t_rot_swap();
    t_returns();
    t_sleep_err();
    give_verdict();
  end
endmodule
